// ==== rtl/wdt_pkg.sv ====
// Constants, field layouts and state encodings of the windowed watchdog
package wdt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register index map on the 3-bit port
	localparam logic [2:0] ADDR_CTL0 = 3'h0;
	localparam logic [2:0] ADDR_CTL1 = 3'h1;
	localparam logic [2:0] ADDR_PWR = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	localparam logic [2:0] ADDR_CNT_LO = 3'h4;
	localparam logic [2:0] ADDR_CNT_MID = 3'h5;
	localparam logic [2:0] ADDR_CNT_HI = 3'h6;

	// Field positions
	localparam int CTL0_SWEN_BIT = 0;
	localparam int CTL0_PS_LSB = 1;
	localparam int CTL1_WIN_LSB = 0;
	localparam int CTL1_CS_LSB = 4;
	localparam int PWR_WV_BIT = 0;
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam int STAT_ARM_BIT = 2;
	localparam int STAT_OPEN_BIT = 3;
	localparam int STAT_ACT_BIT = 4;

	////////////////////////////////////////////////////////////////////////////
	// Modes and selector codes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic [1:0] MODE_AWAKE = 2'h2;
	localparam logic [1:0] MODE_ON = 2'h3;

	localparam logic [2:0] CS_LF = 3'h0;
	localparam logic [2:0] CS_MF = 3'h1;
	localparam logic [2:0] CS_SEC = 3'h2;
	localparam logic [2:0] CS_OPEN = 3'h7;

	localparam logic [2:0] WIN_OPEN = 3'h7;
	localparam logic [2:0] WIN_FULL = 3'h7;

	localparam logic [4:0] PS_OPEN = 5'h1F;
	localparam logic [4:0] PS_DEFAULT = 5'h0B;
	localparam logic [4:0] PS_MAX = 5'h12;
	localparam logic [4:0] PS_BASE_SHIFT = 5'h05;
	localparam logic [4:0] WIN_EIGHTH_SHIFT = 5'h03;

	////////////////////////////////////////////////////////////////////////////
	// Counter geometry and time-base divider
	localparam int PRE_W = 18;
	localparam int CNT_W = 23;
	localparam int MF_DIV_W = 4;
	localparam logic [3:0] MF_DIV_LAST = 4'hF;

	typedef enum logic [1:0] {
		ARM_IDLE = 2'b01,
		ARM_SET = 2'b10
	} arm_state_t;

endpackage

// ==== rtl/timebase_tick.sv ====
// Oscillator synchronisers and watchdog time-base selector
`timescale 1ns/1ps
module timebase_tick (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic osc_lf,
	input wire logic osc_mf,
	input wire logic osc_sec,
	input wire logic [2:0] sel,
	output logic tick
);

	logic [2:0] osc_in;
	logic [2:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next, rise;
	logic [3:0] div_reg, div_next;
	logic tick_next;

	assign osc_in = {osc_sec, osc_mf, osc_lf};

	// Three stages per source; a level counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_sync
			always_comb
			begin
				stable_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : stable_reg[g];
				rise[g] = stable_next[g] & ~stable_reg[g];
			end
		end
	endgenerate

	always_comb
	begin
		div_next = div_reg;
		if (rise[1])
			div_next = div_reg + 4'h1;
		case (sel)
			wdt_pkg::CS_LF: tick_next = rise[0];
			wdt_pkg::CS_MF: tick_next = rise[1] && (div_reg == wdt_pkg::MF_DIV_LAST);
			wdt_pkg::CS_SEC: tick_next = rise[2];
			default: tick_next = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
			stable_reg <= 3'h0;
			div_reg <= 4'h0;
			tick <= 1'b0;
		end
		else
		begin
			s1_reg <= osc_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stable_reg <= stable_next;
			div_reg <= div_next;
			tick <= tick_next;
		end
	end

endmodule // timebase_tick

// ==== rtl/prescale_counter.sv ====
// Watchdog prescale and period counter with synchronous clear
`timescale 1ns/1ps
module prescale_counter #(
	parameter int WIDTH = 23
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic inc,
	output logic [WIDTH-1:0] count
);

	logic [WIDTH-1:0] count_next;

	// Clear beats increment so a restart never loses a cycle
	always_comb
	begin
		count_next = count;
		if (clear)
			count_next = '0;
		else if (inc)
			count_next = count + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			count <= '0;
		else
			count <= count_next;
	end

endmodule // prescale_counter

// ==== rtl/windowed_watchdog_timer.sv ====
// Windowed watchdog timer: control registers, window check and reset/wake generation
`timescale 1ns/1ps
module windowed_watchdog_timer (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic low_freq_internal_osc,
	input wire logic mid_freq_internal_osc,
	input wire logic secondary_osc,
	input wire logic [1:0] wd_mode_cfg,
	input wire logic [2:0] timebase_cfg,
	input wire logic [2:0] window_cfg,
	input wire logic [4:0] period_cfg,
	input wire logic sleep_active,
	input wire logic watchdog_clear_command,
	input wire logic osc_startup_timer,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	output logic wdt_reset_req,
	output logic wake_req,
	output logic timeout_status_bit,
	output logic powerdown_status_bit,
	output logic window_violation_flag_n
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding for the counter compare, the window check and the mode enable

	function automatic logic [4:0] ratio_shift(input logic [4:0] ps);
		if (ps > wdt_pkg::PS_MAX)
			ratio_shift = wdt_pkg::PS_BASE_SHIFT;
		else
			ratio_shift = ps + wdt_pkg::PS_BASE_SHIFT;
	endfunction

	function automatic logic [22:0] terminal_count(input logic [4:0] ps);
		logic [23:0] full;
		full = 24'h000001 << ratio_shift(ps);
		terminal_count = full[22:0] - 23'h000001;
	endfunction

	function automatic logic [22:0] window_start(input logic [4:0] ps, input logic [2:0] win);
		logic [2:0] closed;
		logic [25:0] t;
		closed = wdt_pkg::WIN_FULL - win;
		t = {23'h000000, closed} << (ratio_shift(ps) - wdt_pkg::WIN_EIGHTH_SHIFT);
		window_start = t[22:0];
	endfunction

	function automatic logic wd_active(input logic [1:0] mode, input logic swen,
		input logic asleep);
		case (mode)
			wdt_pkg::MODE_ON: wd_active = 1'b1;
			wdt_pkg::MODE_AWAKE: wd_active = !asleep;
			wdt_pkg::MODE_SOFT: wd_active = swen;
			default: wd_active = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic loaded_reg, loaded_next;
	logic [4:0] period_reg, period_next;
	logic swen_reg, swen_next;
	logic [2:0] tbsel_reg, tbsel_next;
	logic [2:0] win_reg, win_next;
	logic flag_n_next, to_next, pd_next, reset_next, wake_next;
	logic sleep_d_reg;
	logic [7:0] rdata_next;
	wdt_pkg::arm_state_t arm_reg, arm_next;

	logic tick, active, windowed, window_open, at_term, expire;
	logic clr_cmd, bad_clear, good_clear, sleep_edge, ctl_write, cnt_clear;
	logic [22:0] count;

	timebase_tick u_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.osc_lf(low_freq_internal_osc),
		.osc_mf(mid_freq_internal_osc),
		.osc_sec(secondary_osc),
		.sel(tbsel_reg),
		.tick(tick)
	);

	prescale_counter #(
		.WIDTH(wdt_pkg::CNT_W)
	) u_count (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(cnt_clear),
		.inc(tick && active),
		.count(count)
	);

	////////////////////////////////////////////////////////////////////////////
	// Watchdog decisions

	always_comb
	begin
		active = loaded_reg && wd_active(wd_mode_cfg, swen_reg, sleep_active);
		windowed = (win_reg != wdt_pkg::WIN_OPEN);
		window_open = (count >= window_start(period_reg, win_reg));
		at_term = (count == terminal_count(period_reg));
		expire = tick && active && at_term;
		clr_cmd = watchdog_clear_command && active;
		// Unarmed or early clear in windowed mode
		bad_clear = clr_cmd && windowed
			&& (arm_reg != wdt_pkg::ARM_SET || !window_open);
		good_clear = clr_cmd && !bad_clear;
		sleep_edge = (sleep_active != sleep_d_reg);
		ctl_write = wr_en && (addr == wdt_pkg::ADDR_CTL0 || addr == wdt_pkg::ADDR_CTL1);
		cnt_clear = !active || good_clear || bad_clear || expire || sleep_edge
			|| osc_startup_timer || ctl_write;
		reset_next = (expire && !sleep_active) || bad_clear;
		wake_next = expire && sleep_active;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers, straps and status

	always_comb
	begin
		loaded_next = 1'b1;
		period_next = period_reg;
		swen_next = swen_reg;
		tbsel_next = tbsel_reg;
		win_next = win_reg;
		flag_n_next = window_violation_flag_n;
		to_next = timeout_status_bit;
		pd_next = powerdown_status_bit;
		arm_next = arm_reg;
		// Straps are taken on the first cycle after release, not under reset
		if (!loaded_reg)
		begin
			period_next = (period_cfg == wdt_pkg::PS_OPEN) ? wdt_pkg::PS_DEFAULT : period_cfg;
			tbsel_next = (timebase_cfg == wdt_pkg::CS_OPEN) ? wdt_pkg::CS_LF : timebase_cfg;
			win_next = window_cfg;
		end
		else if (wr_en)
		begin
			if (addr == wdt_pkg::ADDR_CTL0)
			begin
				swen_next = wdata[wdt_pkg::CTL0_SWEN_BIT];
				if (period_cfg == wdt_pkg::PS_OPEN)
					period_next = wdata[wdt_pkg::CTL0_PS_LSB +: 5];
			end
			if (addr == wdt_pkg::ADDR_CTL1)
			begin
				if (timebase_cfg == wdt_pkg::CS_OPEN)
					tbsel_next = wdata[wdt_pkg::CTL1_CS_LSB +: 3];
				if (window_cfg == wdt_pkg::WIN_OPEN)
					win_next = wdata[wdt_pkg::CTL1_WIN_LSB +: 3];
			end
			if (addr == wdt_pkg::ADDR_PWR)
				flag_n_next = wdata[wdt_pkg::PWR_WV_BIT];
		end
		// Hardware event beats a same-cycle software write
		if (bad_clear)
			flag_n_next = 1'b0;
		if (rd_en && addr == wdt_pkg::ADDR_CTL0)
			arm_next = wdt_pkg::ARM_SET;
		if (clr_cmd)
			arm_next = wdt_pkg::ARM_IDLE;
		case (arm_next)
			wdt_pkg::ARM_IDLE: arm_next = wdt_pkg::ARM_IDLE;
			wdt_pkg::ARM_SET: arm_next = wdt_pkg::ARM_SET;
			default: arm_next = wdt_pkg::ARM_IDLE;
		endcase
		if (good_clear)
		begin
			to_next = 1'b1;
			pd_next = 1'b1;
		end
		if (sleep_active && !sleep_d_reg)
			pd_next = 1'b0;
		if (expire)
			to_next = 1'b0;
	end

	always_comb
	begin
		rdata_next = 8'h00;
		if (rd_en)
		begin
			case (addr)
				wdt_pkg::ADDR_CTL0: rdata_next = {2'h0, period_reg, swen_reg};
				wdt_pkg::ADDR_CTL1: rdata_next = {1'b0, tbsel_reg, 1'b0, win_reg};
				wdt_pkg::ADDR_PWR: rdata_next = {7'h00, window_violation_flag_n};
				wdt_pkg::ADDR_STAT: rdata_next = {3'h0, active, window_open,
					arm_reg == wdt_pkg::ARM_SET, powerdown_status_bit, timeout_status_bit};
				wdt_pkg::ADDR_CNT_LO: rdata_next = count[7:0];
				wdt_pkg::ADDR_CNT_MID: rdata_next = count[15:8];
				wdt_pkg::ADDR_CNT_HI: rdata_next = {1'b0, count[22:16]};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loaded_reg <= 1'b0;
			period_reg <= wdt_pkg::PS_DEFAULT;
			swen_reg <= 1'b0;
			tbsel_reg <= wdt_pkg::CS_LF;
			win_reg <= wdt_pkg::WIN_OPEN;
			window_violation_flag_n <= 1'b1;
			timeout_status_bit <= 1'b1;
			powerdown_status_bit <= 1'b1;
			arm_reg <= wdt_pkg::ARM_IDLE;
			sleep_d_reg <= 1'b0;
			wdt_reset_req <= 1'b0;
			wake_req <= 1'b0;
			rdata <= 8'h00;
		end
		else
		begin
			loaded_reg <= loaded_next;
			period_reg <= period_next;
			swen_reg <= swen_next;
			tbsel_reg <= tbsel_next;
			win_reg <= win_next;
			window_violation_flag_n <= flag_n_next;
			timeout_status_bit <= to_next;
			powerdown_status_bit <= pd_next;
			arm_reg <= arm_next;
			sleep_d_reg <= sleep_active;
			wdt_reset_req <= reset_next;
			wake_req <= wake_next;
			rdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_unarmed_clear;
		watchdog_clear_command && active && windowed && arm_reg == wdt_pkg::ARM_IDLE;
	endsequence

	sequence s_violation_out;
		wdt_reset_req && !window_violation_flag_n;
	endsequence

	sequence s_awake_expiry;
		tick && active && at_term && !sleep_active;
	endsequence

	a_off_mode_idle: assert property (wd_mode_cfg == wdt_pkg::MODE_OFF
		|=> count == 23'h0 && !wdt_reset_req)
		else $error("counter moved in off mode");
	a_soft_disable: assert property (wd_mode_cfg == wdt_pkg::MODE_SOFT && !swen_reg
		|=> count == 23'h0)
		else $error("counter moved with soft enable clear");
	a_sleep_stop: assert property (wd_mode_cfg == wdt_pkg::MODE_AWAKE && sleep_active
		|=> count == 23'h0)
		else $error("counter moved in sleep in awake mode");
	a_sleep_wake: assert property (wd_mode_cfg == wdt_pkg::MODE_ON && sleep_active
		&& tick && at_term && loaded_reg
		|=> wake_req && !wdt_reset_req ##1 !timeout_status_bit)
		else $error("sleep expiry did not wake");
	a_expiry_reset: assert property (s_awake_expiry |=> wdt_reset_req ##1 !wdt_reset_req)
		else $error("expiry reset pulse wrong");
	a_unarmed_clear: assert property (s_unarmed_clear |=> s_violation_out)
		else $error("unarmed clear not a violation");
	a_early_clear: assert property (watchdog_clear_command && active && windowed
		&& !window_open |=> wdt_reset_req)
		else $error("clear in closed window missed");
	a_write_restart: assert property (wr_en && addr == wdt_pkg::ADDR_CTL1 |=> count == 23'h0)
		else $error("control write did not restart counter");
	// Reserved codes must expire at the 32nd tick, not roll on past it
	a_reserved_ratio: assert property (period_reg > wdt_pkg::PS_MAX && tick && active
		&& count == 23'h00001F |=> count == 23'h0 && (wdt_reset_req || wake_req))
		else $error("reserved period code not minimum");
	a_full_window: assert property (win_reg == wdt_pkg::WIN_OPEN
		&& watchdog_clear_command && active && !at_term |=> !wdt_reset_req)
		else $error("clear in full window refused");

endmodule // windowed_watchdog_timer

// ==== verification/core_model.sv ====
// Core-side model: clear instructions and sleep state toward the watchdog
`timescale 1ns/1ps
module core_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clr_req,
	input wire logic sleep_req,
	output logic watchdog_clear_command,
	output logic sleep_active
);
	logic req_reg;
	logic req_next;
	logic cmd_next;

	////////////////////////////////////////
	// One pulse per request edge, as one clear instruction gives
	always_comb
	begin
		req_next = clr_req;
		cmd_next = clr_req & ~req_reg;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_reg <= 1'b0;
			watchdog_clear_command <= 1'b0;
			sleep_active <= 1'b0;
		end
		else
		begin
			req_reg <= req_next;
			watchdog_clear_command <= cmd_next;
			sleep_active <= sleep_req;
		end
	end
endmodule // core_model

// ==== verification/windowed_watchdog_timer_test.sv ====
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
	logic mclk, rst_n, osc_lf, osc_mf, osc_sec, clr_req, sleep_req, sleep_active, clr_cmd;
	logic osc_startup_timer, wr_en, rd_en, wdt_reset_req, wake_req, r;
	logic timeout_status_bit, powerdown_status_bit, window_violation_flag_n;
	logic [1:0] wd_mode_cfg;
	logic [2:0] addr;
	logic [7:0] wdata, rdata;
	int n_fail = 0;
	int cmp_count = 0;

	////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Time bases far slower than mclk and out of phase with it
	initial
	begin
		osc_lf = 1'b0;
		forever #320 osc_lf = ~osc_lf;
	end
	initial
	begin
		osc_mf = 1'b0;
		#3;
		forever #320 osc_mf = ~osc_mf;
	end
	initial
	begin
		osc_sec = 1'b0;
		#11;
		forever #320 osc_sec = ~osc_sec;
	end

	windowed_watchdog_timer windowed_watchdog_timer_i (.mclk(mclk), .rst_n(rst_n),
		.low_freq_internal_osc(osc_lf), .mid_freq_internal_osc(osc_mf),
		.secondary_osc(osc_sec), .wd_mode_cfg(wd_mode_cfg), .timebase_cfg(3'h7),
		.window_cfg(3'h7), .period_cfg(5'h1F), .sleep_active(sleep_active),
		.watchdog_clear_command(clr_cmd), .osc_startup_timer(osc_startup_timer),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.wdt_reset_req(wdt_reset_req), .wake_req(wake_req),
		.timeout_status_bit(timeout_status_bit), .powerdown_status_bit(powerdown_status_bit),
		.window_violation_flag_n(window_violation_flag_n));

	core_model core_model_i (.mclk(mclk), .rst_n(rst_n), .clr_req(clr_req),
		.sleep_req(sleep_req), .watchdog_clear_command(clr_cmd), .sleep_active(sleep_active));

	////////////////////////////////////////
	task automatic chk(input bit ok, input string m);
		cmp_count++;
		if (!ok)
		begin
			n_fail++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string m);
		logic [7:0] d;
		rd(a, d);
		chk(d === e, m);
	endtask

	task automatic clr_watch();
		@(posedge mclk);
		clr_req <= 1'b1;
		@(posedge mclk);
		clr_req <= 1'b0;
		r = 1'b0;
		repeat (4)
		begin
			@(posedge mclk);
			#1 r = r | wdt_reset_req;
		end
	endtask

	// Polls the live count until it reaches 28, the narrowest window's opening
	task automatic wait_window();
		logic [7:0] c;
		int n;
		c = 8'h00;
		n = 0;
		while (c < 8'h1C && n < 400)
		begin
			rd(wdt_pkg::ADDR_CNT_LO, c);
			n++;
		end
		chk(n < 400, "count never reached window");
	endtask

	// Expected outcome: 0 none, 1 device reset, 2 wake
	task automatic run_case(input logic [1:0] m, input logic sw, input logic sl,
		input logic st, input logic [2:0] cs, input logic [4:0] per, input int e);
		int tk, t, n;
		logic hit;
		tk = (per > 5'h12) ? 32 : (32 << per);
		t = (cs == 3'h1) ? 256 : 16;
		n = 0;
		hit = 1'b0;
		@(posedge mclk);
		wd_mode_cfg <= m;
		sleep_req <= sl;
		osc_startup_timer <= st;
		wr(wdt_pkg::ADDR_CTL1, {1'b0, cs, 4'h7});
		wr(wdt_pkg::ADDR_CTL0, {2'b00, per, sw});
		while (!hit && n < tk * t + 40)
		begin
			@(posedge mclk);
			#1 n++;
			hit = (wdt_reset_req === 1'b1) || (wake_req === 1'b1);
		end
		chk(wdt_reset_req === (e == 1) && wake_req === (e == 2), "wrong expiry outcome");
		if (e != 0)
		begin
			chk(n >= (tk - 1) * t && n <= tk * t + 8, "expiry at wrong time");
			repeat (2) @(posedge mclk);
			#1 chk(timeout_status_bit === 1'b0, "timeout bit kept");
			if (sl)
				chk(powerdown_status_bit === 1'b0, "powerdown bit kept");
		end
		$display("Case mode %0d clock %0d period %0d done", m, cs, per);
	endtask

	////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		clr_req = 1'b0;
		sleep_req = 1'b0;
		osc_startup_timer = 1'b0;
		wd_mode_cfg = 2'h3;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rdc(wdt_pkg::ADDR_CTL0, 8'h16, "control zero after reset");
		rdc(wdt_pkg::ADDR_CTL1, 8'h07, "control one after reset");
		rdc(wdt_pkg::ADDR_PWR, 8'h01, "violation flag after reset");
		rdc(3'h7, 8'h00, "unmapped read");
		$display("Reset values done");
		run_case(2'h3, 1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 1);
		run_case(2'h3, 1'b0, 1'b1, 1'b0, 3'h0, 5'h00, 2);
		run_case(2'h2, 1'b0, 1'b0, 1'b0, 3'h2, 5'h01, 1);
		run_case(2'h2, 1'b0, 1'b1, 1'b0, 3'h0, 5'h00, 0);
		run_case(2'h1, 1'b1, 1'b0, 1'b0, 3'h0, 5'h13, 1);
		run_case(2'h1, 1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 0);
		run_case(2'h0, 1'b1, 1'b0, 1'b0, 3'h0, 5'h00, 0);
		run_case(2'h3, 1'b0, 1'b0, 1'b1, 3'h0, 5'h00, 0);
		run_case(2'h3, 1'b0, 1'b0, 1'b0, 3'h1, 5'h00, 1);
		run_case(2'h3, 1'b0, 1'b0, 1'b0, 3'h3, 5'h00, 0);
		// Narrowest window: only counts 28..31 of 32 accept a clear
		wr(wdt_pkg::ADDR_CTL1, 8'h00);
		rdc(wdt_pkg::ADDR_CTL0, 8'h00, "control zero readback");
		// Armed but early, so only the closed window can refuse it
		clr_watch();
		chk(r === 1'b1 && window_violation_flag_n === 1'b0, "early clear taken");
		wr(wdt_pkg::ADDR_PWR, 8'h01);
		rdc(wdt_pkg::ADDR_PWR, 8'h01, "flag not set by write");
		// The early clear disarmed; this one falls in the window unarmed
		wait_window();
		clr_watch();
		chk(r === 1'b1 && window_violation_flag_n === 1'b0, "unarmed clear taken");
		wr(wdt_pkg::ADDR_PWR, 8'h01);
		wr(wdt_pkg::ADDR_CTL0, 8'h00);
		wait_window();
		rdc(wdt_pkg::ADDR_CTL0, 8'h00, "arming read");
		clr_watch();
		chk(r === 1'b0 && window_violation_flag_n === 1'b1, "armed clear refused");
		chk(timeout_status_bit === 1'b1, "valid clear left timeout bit");
		// Full window needs no arming read
		wr(wdt_pkg::ADDR_CTL1, 8'h07);
		clr_watch();
		chk(r === 1'b0 && window_violation_flag_n === 1'b1, "open clear refused");
		$display("Window cases done");
		give_verdict();
	end
endmodule // windowed_watchdog_timer_test
